/* rtl/ppm_ctrl.sv */
// prescaler and low-power mode controller top
// assumes irq_req, irq_enable, ccr_mask and sleep_req come from logic on clk_sys;
// reset_pin_n and sub_clk_div4 are pins and are synchronised here
// Summary of operation
// R1: system prescaler is a 13-bit counter advancing once per system clock period
// R2: reset clears system prescaler; counting starts on leaving reset state
// R3: standby, subactive, subsleep stop the system prescaler and force it to zero
// R4: system prescaler count has no software-visible register
// R5: in active and sleep, prescaler input divided by the divide select field
// R6: prescaler outputs shared by all peripherals, each picks its own tap
// R7: subclock prescaler is 5-bit, clocked by the subclock divided by four
// R8: reset clears subclock prescaler; counting starts on leaving reset state
// R9: subclock prescaler keeps counting in standby, subactive and subsleep
// R10: writing both time-base clear bits clears subclock prescaler; outputs feed timer
// R11: sleep halts the processor, keeps registers, peripherals keep running
// R12: enabled unmasked interrupt ends sleep and starts exception handling
// R13: leaving sleep goes to subactive if low speed select set, else active
// R14: reset pin low during sleep ends sleep and resets the processor
// R15: standby stops clock, halts processor and peripherals, ports go high impedance
// R16: interrupt in standby restarts clock, exception after selected settle delay
// R17: standby persists while mask set or the interrupt is disabled
// R18: external source holds reset pin low until restarted clock is stable
// R19: subsleep halts all but subclock timer and holds ports at previous states
// R20: enabled unmasked interrupt ends subsleep and starts exception handling
// R21: leaving subsleep picks active or subactive by low speed select
`timescale 1ns/100ps

module ppm_ctrl #(
	parameter int SETTLE_BASE = ppm_pkg::SETTLE_BASE_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  reset_pin_n,
	input  wire logic                  sub_clk_div4,
	input  wire logic [7:0]            irq_req,
	input  wire logic [7:0]            irq_enable,
	input  wire logic                  ccr_mask,
	input  wire logic                  sleep_req,
	input  wire ppm_pkg::ppm_bus_req_t bus_req,
	output logic      [7:0]            bus_rdata,
	output logic      [12:0]           sys_presc,
	output logic      [4:0]            sub_presc,
	output ppm_pkg::ppm_status_t       power_status,
	output logic                       exception_start,
	output ppm_pkg::ppm_mode_t         mode
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [7:0]          system_control_one;
	logic [7:0]          system_control_two;
	logic [1:0]          timer_mode_low;
	logic [1:0]          rst_pin_sync;
	logic [2:0]          sub_clk_sync;
	logic                rst_pin_low;
	logic                sub_edge;
	logic                tb_clear;
	logic                wake;
	logic                standby_select;
	logic                low_speed_select;
	logic [2:0]          div_sel;
	logic [2:0]          settle_sel;
	logic [6:0]          div_cnt;
	logic [6:0]          div_mask;
	logic                sys_tick;
	logic                sys_running;
	logic [23:0]         settle_cnt;
	logic [23:0]         settle_limit;
	ppm_pkg::ppm_mode_t  next_mode;
	ppm_pkg::ppm_mode_t  wake_target;
	ppm_pkg::ppm_status_t next_status;
	logic                next_exception;

	assign standby_select   = system_control_one[ppm_pkg::POS_STANDBY_SELECT];
	assign settle_sel       = system_control_one[ppm_pkg::POS_SETTLE_SEL_LO +: 3];
	assign low_speed_select = system_control_two[ppm_pkg::POS_LOW_SPEED_SELECT];
	assign div_sel          = system_control_two[ppm_pkg::POS_DIV_SEL_LO +: 3];

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// reset pin and subclock pass two flops before use
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rst_pin_sync <= 2'h0;
			sub_clk_sync <= 3'h0;
		end else begin
			rst_pin_sync <= {rst_pin_sync[0], reset_pin_n};
			sub_clk_sync <= {sub_clk_sync[1:0], sub_clk_div4};
		end
	end

	assign rst_pin_low = ~rst_pin_sync[1];
	// rising edge seen only on synchronised stages
	assign sub_edge    = sub_clk_sync[1] & ~sub_clk_sync[2];

	// ************************************************************
	// register port
	// ************************************************************
	// both time-base clear bits written as ones
	assign tb_clear = bus_req.wr && (bus_req.addr == ppm_pkg::ADDR_TIMER_MODE_REG) &&
		bus_req.wdata[ppm_pkg::POS_TIMEBASE_CLEAR_HI] &&
		bus_req.wdata[ppm_pkg::POS_TIMEBASE_CLEAR_LO]; // R10

	// software writes of control registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			system_control_one <= ppm_pkg::RST_SYSTEM_CONTROL_ONE;
			system_control_two <= ppm_pkg::RST_SYSTEM_CONTROL_TWO;
			timer_mode_low     <= ppm_pkg::RST_TIMER_MODE_LOW;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				ppm_pkg::ADDR_SYSTEM_CONTROL_ONE: begin
					system_control_one <= bus_req.wdata;
				end
				ppm_pkg::ADDR_SYSTEM_CONTROL_TWO: begin
					system_control_two <= bus_req.wdata;
				end
				ppm_pkg::ADDR_TIMER_MODE_REG: begin
					timer_mode_low <= bus_req.wdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data one cycle after the strobe; prescaler count is not mapped
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				ppm_pkg::ADDR_SYSTEM_CONTROL_ONE: bus_rdata <= system_control_one;
				ppm_pkg::ADDR_SYSTEM_CONTROL_TWO: bus_rdata <= system_control_two;
				ppm_pkg::ADDR_TIMER_MODE_REG:     bus_rdata <= {6'h00, timer_mode_low};
				ppm_pkg::ADDR_MODE_STATUS:        bus_rdata <= {1'b0, mode};
				default:                          bus_rdata <= 8'h00; // R4
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// ************************************************************
	// system prescaler
	// ************************************************************
	// divide select gives a tick every 2^div_sel source cycles
	assign div_mask    = 7'((8'h01 << div_sel) - 8'h01); // R5
	assign sys_tick    = (div_cnt & div_mask) == div_mask;
	assign sys_running = (mode == ppm_pkg::PPM_ACTIVE) || (mode == ppm_pkg::PPM_SLEEP);

	// source divider, idle while the clock generator is stopped
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_cnt <= ppm_pkg::RST_DIV_CNT;
		end else if (!sys_running) begin
			div_cnt <= ppm_pkg::RST_DIV_CNT;
		end else begin
			div_cnt <= 7'(div_cnt + 7'h01);
		end
	end

	// prescaler count, shared by every peripheral as tap bits
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sys_presc <= ppm_pkg::RST_SYS_PRESC; // R2
		end else if (!sys_running) begin
			sys_presc <= ppm_pkg::RST_SYS_PRESC; // R3
		end else if (sys_tick) begin
			sys_presc <= 13'(sys_presc + 13'h0001); // R1 R6
		end
	end

	// ************************************************************
	// subclock prescaler
	// ************************************************************
	// runs in every mode but the reset state, on synchronised subclock edges
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sub_presc <= ppm_pkg::RST_SUB_PRESC; // R8
		end else if (mode == ppm_pkg::PPM_RESET || tb_clear) begin
			sub_presc <= ppm_pkg::RST_SUB_PRESC; // R8 R10
		end else if (sub_edge) begin
			sub_presc <= 5'(sub_presc + 5'h01); // R7 R9
		end
	end

	// ************************************************************
	// power mode machine
	// ************************************************************
	// wake needs an enabled request and a clear mask
	assign wake         = (|(irq_req & irq_enable)) && !ccr_mask; // R12 R17 R20
	assign wake_target  = low_speed_select ? ppm_pkg::PPM_SUBACTIVE
		: ppm_pkg::PPM_ACTIVE; // R13 R21
	assign settle_limit = 24'(SETTLE_BASE) << settle_sel;

	// next mode and exception pulse
	always_comb begin
		next_mode      = mode;
		next_exception = 1'b0;
		if (rst_pin_low) begin
			next_mode = ppm_pkg::PPM_RESET; // R14
		end else begin
			case (mode)
				ppm_pkg::PPM_RESET: begin
					next_mode = ppm_pkg::PPM_ACTIVE;
				end
				ppm_pkg::PPM_ACTIVE: begin
					if (sleep_req) begin
						next_mode = standby_select ? ppm_pkg::PPM_STANDBY
							: ppm_pkg::PPM_SLEEP;
					end
				end
				ppm_pkg::PPM_SUBACTIVE: begin
					if (sleep_req) begin
						next_mode = standby_select ? ppm_pkg::PPM_STANDBY
							: ppm_pkg::PPM_SUBSLEEP;
					end
				end
				ppm_pkg::PPM_SLEEP: begin
					if (wake) begin
						next_mode      = wake_target; // R12 R13
						next_exception = 1'b1;
					end
				end
				ppm_pkg::PPM_STANDBY: begin
					if (wake) begin
						next_mode = ppm_pkg::PPM_SETTLE; // R16 R17
					end
				end
				ppm_pkg::PPM_SETTLE: begin
					if (settle_cnt >= settle_limit) begin
						next_mode      = wake_target; // R16
						next_exception = 1'b1;
					end
				end
				ppm_pkg::PPM_SUBSLEEP: begin
					if (wake) begin
						next_mode      = wake_target; // R20 R21
						next_exception = 1'b1;
					end
				end
				default: begin
					next_mode = ppm_pkg::PPM_RESET;
				end
			endcase
		end
	end

	// mode register and exception pulse
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode            <= ppm_pkg::PPM_RESET;
			exception_start <= 1'b0;
		end else begin
			mode            <= next_mode;
			exception_start <= next_exception;
		end
	end

	// settle delay counter after a standby wake
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			settle_cnt <= ppm_pkg::RST_SETTLE_CNT;
		end else if (mode == ppm_pkg::PPM_SETTLE) begin
			settle_cnt <= 24'(settle_cnt + 24'h000001); // R16
		end else begin
			settle_cnt <= ppm_pkg::RST_SETTLE_CNT;
		end
	end

	// ************************************************************
	// chip power controls
	// ************************************************************
	// decoded from the next mode so the outputs line up with mode
	always_comb begin
		next_status = '0;
		case (next_mode)
			ppm_pkg::PPM_RESET: begin
				next_status.cpu_reset  = 1'b1; // R14
				next_status.sysclk_run = 1'b1;
				next_status.io_hiz     = 1'b1;
			end
			ppm_pkg::PPM_ACTIVE: begin
				next_status.periph_run   = 1'b1;
				next_status.subtimer_run = 1'b1;
				next_status.sysclk_run   = 1'b1;
			end
			ppm_pkg::PPM_SLEEP: begin
				next_status.cpu_halt     = 1'b1; // R11
				next_status.periph_run   = 1'b1;
				next_status.subtimer_run = 1'b1;
				next_status.sysclk_run   = 1'b1;
			end
			ppm_pkg::PPM_STANDBY: begin
				next_status.cpu_halt     = 1'b1; // R15
				next_status.io_hiz       = 1'b1;
				next_status.subtimer_run = 1'b1;
			end
			ppm_pkg::PPM_SETTLE: begin
				next_status.cpu_halt     = 1'b1; // R16
				next_status.io_hiz       = 1'b1;
				next_status.subtimer_run = 1'b1;
				next_status.sysclk_run   = 1'b1;
			end
			ppm_pkg::PPM_SUBACTIVE: begin
				next_status.periph_run   = 1'b1;
				next_status.subtimer_run = 1'b1;
			end
			ppm_pkg::PPM_SUBSLEEP: begin
				next_status.cpu_halt     = 1'b1; // R19
				next_status.subtimer_run = 1'b1;
				next_status.io_hold      = 1'b1;
			end
			default: begin
				next_status.cpu_reset = 1'b1;
			end
		endcase
	end

	// registered power controls
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			power_status <= ppm_pkg::RST_POWER_STATUS;
		end else begin
			power_status <= next_status;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking ppm_cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence wake_in_sleep_s;
		mode == ppm_pkg::PPM_SLEEP && !rst_pin_low && wake;
	endsequence

	sequence standby_wake_s;
		mode == ppm_pkg::PPM_STANDBY && !rst_pin_low && wake;
	endsequence

	presc_step_a: assert property (sys_running && next_mode == mode && sys_tick // R1
		|=> sys_presc == 13'($past(sys_presc) + 13'h0001))
		else $error("system prescaler did not step");

	presc_reset_a: assert property (mode == ppm_pkg::PPM_RESET |=> sys_presc == 13'h0000) // R2
		else $error("system prescaler not clear in reset");

	presc_stop_a: assert property ((mode == ppm_pkg::PPM_STANDBY || // R3
		mode == ppm_pkg::PPM_SUBACTIVE || mode == ppm_pkg::PPM_SUBSLEEP)
		|=> sys_presc == 13'h0000)
		else $error("system prescaler not stopped");

	tb_clear_a: assert property (tb_clear |=> sub_presc == 5'h00) // R10
		else $error("time base not cleared");

	sub_run_a: assert property (mode == ppm_pkg::PPM_STANDBY && !rst_pin_low && // R9
		sub_edge && !tb_clear |=> sub_presc == 5'($past(sub_presc) + 5'h01))
		else $error("subclock prescaler stalled in standby");

	sleep_wake_a: assert property (wake_in_sleep_s |=> // R12
		mode == (low_speed_select ? ppm_pkg::PPM_SUBACTIVE : ppm_pkg::PPM_ACTIVE) // R13
		&& exception_start)
		else $error("sleep did not end on interrupt");

	standby_hold_a: assert property (mode == ppm_pkg::PPM_STANDBY && !rst_pin_low // R17
		&& !wake |=> mode == ppm_pkg::PPM_STANDBY && power_status.io_hiz) // R15
		else $error("standby left without wake");

	settle_len_a: assert property (standby_wake_s |=> (mode == ppm_pkg::PPM_SETTLE // R16
		&& !exception_start)[*2])
		else $error("standby exit skipped settle delay");

	settle_end_a: assert property (mode == ppm_pkg::PPM_SETTLE && !rst_pin_low // R16
		&& next_mode != ppm_pkg::PPM_SETTLE |-> settle_cnt >= settle_limit)
		else $error("settle ended early");

	reset_pin_a: assert property (rst_pin_low |=> mode == ppm_pkg::PPM_RESET // R14
		&& power_status.cpu_reset)
		else $error("reset pin did not reset");

	subsleep_a: assert property (mode == ppm_pkg::PPM_SUBSLEEP |-> power_status.io_hold // R19
		&& power_status.cpu_halt && !power_status.periph_run)
		else $error("subsleep controls wrong");

	subsleep_wake_a: assert property (mode == ppm_pkg::PPM_SUBSLEEP && !rst_pin_low // R20
		&& wake |=> mode != ppm_pkg::PPM_SUBSLEEP && exception_start) // R21
		else $error("subsleep did not end on interrupt");

endmodule // ppm_ctrl

/* rtl/ppm_pkg.sv */
// package for the prescaler and power mode controller
// assumes a single 100 MHz system clock and an 8-bit register port
package ppm_pkg;

	// ************************************************************
	// register map and fields
	// ************************************************************
	localparam logic [3:0] ADDR_SYSTEM_CONTROL_ONE = 4'h0;
	localparam logic [3:0] ADDR_SYSTEM_CONTROL_TWO = 4'h1;
	localparam logic [3:0] ADDR_TIMER_MODE_REG     = 4'h2;
	localparam logic [3:0] ADDR_MODE_STATUS        = 4'h3;

	// system_control_one fields
	localparam int POS_STANDBY_SELECT   = 7;
	localparam int POS_SETTLE_SEL_LO    = 4;
	// system_control_two fields
	localparam int POS_LOW_SPEED_SELECT = 3;
	localparam int POS_DIV_SEL_LO       = 0;
	// timer_mode_reg fields
	localparam int POS_TIMEBASE_CLEAR_HI = 3;
	localparam int POS_TIMEBASE_CLEAR_LO = 2;

	// values after reset
	localparam logic [7:0]  RST_SYSTEM_CONTROL_ONE = 8'h00;
	localparam logic [7:0]  RST_SYSTEM_CONTROL_TWO = 8'h00;
	localparam logic [1:0]  RST_TIMER_MODE_LOW     = 2'h0;
	localparam logic [12:0] RST_SYS_PRESC          = 13'h0000;
	localparam logic [4:0]  RST_SUB_PRESC          = 5'h00;
	localparam logic [6:0]  RST_DIV_CNT            = 7'h00;
	localparam logic [23:0] RST_SETTLE_CNT         = 24'h000000;
	// power controls while held in reset: cpu_reset, io_hiz, sysclk_run
	localparam logic [6:0]  RST_POWER_STATUS       = 7'h25;

	// settle time base, in system clock cycles, shifted by the select field
	localparam int SETTLE_BASE_CYC = 8192;

	// ************************************************************
	// power modes, one-hot
	// ************************************************************
	typedef enum logic [6:0] {
		PPM_RESET     = 7'h01,
		PPM_ACTIVE    = 7'h02,
		PPM_SLEEP     = 7'h04,
		PPM_STANDBY   = 7'h08,
		PPM_SETTLE    = 7'h10,
		PPM_SUBACTIVE = 7'h20,
		PPM_SUBSLEEP  = 7'h40
	} ppm_mode_t;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppm_bus_req_t;

	// chip-wide power control lines
	typedef struct packed {
		logic cpu_halt;
		logic cpu_reset;
		logic periph_run;
		logic subtimer_run;
		logic io_hiz;
		logic io_hold;
		logic sysclk_run;
	} ppm_status_t;

endpackage

/* test/ppm_cpu_model.sv */
// model of the processor core and interrupt logic beside the power controller
// assumes clk_sys rising edge timing and a pulled-up reset pin
`timescale 1ns/100ps

module ppm_cpu_model (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       exception_start,
	output logic      [7:0] irq_req,
	output logic            sleep_req,
	output logic            reset_pin_n
);
	// ************************************************************
	// request lines
	// ************************************************************
	initial begin
		irq_req = 8'h00;
		sleep_req = 1'b0;
		reset_pin_n = 1'b1;
	end

	// handling started or chip reset, request source withdraws
	always @(posedge clk_sys) begin
		if (reset || exception_start) begin
			irq_req <= 8'h00;
		end
	end

	// raise pending requests
	task automatic raise_irq(input logic [7:0] m);
		@(posedge clk_sys);
		irq_req <= irq_req | m;
	endtask

	// one-cycle sleep instruction pulse
	task automatic do_sleep();
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		@(posedge clk_sys);
		sleep_req <= 1'b0;
	endtask

	// hold pin low for n system clock cycles, then release
	task automatic pin_reset(input int n);
		@(posedge clk_sys);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		reset_pin_n <= 1'b1;
	endtask
endmodule // ppm_cpu_model

/* test/tb_top.sv */
// self-checking bench for the prescaler and power mode controller
// assumes ppm_pkg and ppm_ctrl compiled first, settle base shortened to 4
`timescale 1ns/100ps

module tb_top;
	logic                  clk_sys;
	logic                  reset;
	logic                  sub_clk_div4;
	logic [7:0]            irq_enable;
	logic                  ccr_mask;
	ppm_pkg::ppm_bus_req_t bus_req;
	logic [7:0]            bus_rdata;
	logic [12:0]           sys_presc;
	logic [4:0]            sub_presc;
	ppm_pkg::ppm_status_t  power_status;
	logic                  exception_start;
	ppm_pkg::ppm_mode_t    mode;
	logic [7:0]            irq_req;
	logic                  sleep_req;
	logic                  reset_pin_n;
	int                    n_errors;
	int                    checks_done;

	ppm_ctrl #(.SETTLE_BASE(4)) ppm_ctrl_inst (
		.clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n),
		.sub_clk_div4(sub_clk_div4), .irq_req(irq_req), .irq_enable(irq_enable),
		.ccr_mask(ccr_mask), .sleep_req(sleep_req), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .sys_presc(sys_presc), .sub_presc(sub_presc),
		.power_status(power_status), .exception_start(exception_start), .mode(mode)
	);

	ppm_cpu_model ppm_cpu_model_inst (
		.clk_sys(clk_sys), .reset(reset), .exception_start(exception_start),
		.irq_req(irq_req), .sleep_req(sleep_req), .reset_pin_n(reset_pin_n)
	);

	// ************************************************************
	// clocks
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// subclock pin, always supplied
	initial begin
		sub_clk_div4 = 1'b0;
		forever #40 sub_clk_div4 = ~sub_clk_div4;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= ppm_pkg::ppm_bus_req_t'{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus_req <= ppm_pkg::ppm_bus_req_t'{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus_req <= '0;
		#1 chk(16'(bus_rdata), 16'(e));
	endtask

	// bounded wait for a mode
	task automatic wait_mode(input logic [6:0] m);
		int i;
		for (i = 0; i < 60 && mode !== m; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(16'(mode), 16'(m));
		if (i == 60) print_verdict();
	endtask

	// cycles until handling starts
	task automatic wait_exc(output int n);
		for (n = 0; n < 200 && exception_start !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		if (n == 200) begin
			n_errors++;
			print_verdict();
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		logic [12:0] a;
		chk(16'(sys_presc), 16'h0000);
		wait_mode(7'h02);
		a = sys_presc;
		@(posedge clk_sys);
		#1 chk(16'(sys_presc), 16'(a + 13'h0001));
		for (int k = 0; k < 3; k++) rd_chk(4'(k), 8'h00);
		rd_chk(4'h3, 8'h02);
		wr_reg(4'h3, 8'h40);
		rd_chk(4'h3, 8'h02);
		for (int k = 4; k < 16; k++) rd_chk(4'(k), 8'h00);
		$display("test reset done");
	endtask

	// every divide code, four increments per window
	task automatic t_div();
		logic [12:0] a;
		for (int s = 0; s < 8; s++) begin
			wr_reg(4'h1, 8'(s));
			#1 a = sys_presc;
			repeat (4 << s) @(posedge clk_sys);
			#1 chk(16'(sys_presc), 16'(a + 13'h0004));
		end
		wr_reg(4'h1, 8'h00);
		$display("test divide done");
	endtask

	task automatic t_sleep();
		logic [12:0] a;
		int n;
		ccr_mask <= 1'b1;
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h04);
		chk(16'(power_status.cpu_halt), 16'h0001);
		a = sys_presc;
		ppm_cpu_model_inst.raise_irq(8'h01);
		repeat (10) @(posedge clk_sys);
		#1 chk(16'(mode), 16'h0004);
		chk(16'(sys_presc !== a), 16'h0001);
		ccr_mask <= 1'b0;
		wait_exc(n);
		chk(16'(n <= 3), 16'h0001);
		chk(16'(mode), 16'h0002);
		$display("test sleep done");
	endtask

	task automatic t_subsleep();
		logic [4:0] a;
		int n;
		wr_reg(4'h1, 8'h08);
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h04);
		ppm_cpu_model_inst.raise_irq(8'h80);
		wait_exc(n);
		chk(16'(mode), 16'h0020);
		#10 chk(16'(sys_presc), 16'h0000);
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h40);
		chk(16'(power_status), 16'h004a);
		a = sub_presc;
		repeat (40) @(posedge clk_sys);
		#1 chk(16'(sub_presc !== a), 16'h0001);
		ppm_cpu_model_inst.raise_irq(8'h02);
		wait_exc(n);
		chk(16'(mode), 16'h0020);
		wr_reg(4'h1, 8'h00);
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h40);
		ppm_cpu_model_inst.raise_irq(8'h04);
		wait_exc(n);
		chk(16'(mode), 16'h0002);
		$display("test subsleep done");
	endtask

	task automatic t_standby();
		int n;
		wr_reg(4'h0, 8'h90);
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h08);
		chk(16'({power_status.cpu_halt, power_status.io_hiz}), 16'h0003);
		chk(16'(sys_presc), 16'h0000);
		irq_enable <= 8'hef;
		ppm_cpu_model_inst.raise_irq(8'h10);
		repeat (10) @(posedge clk_sys);
		#1 chk(16'(mode), 16'h0008);
		irq_enable <= 8'hff;
		wait_exc(n);
		chk(16'(n >= 8 && n <= 11), 16'h0001);
		chk(16'(mode), 16'h0002);
		wr_reg(4'h0, 8'h00);
		$display("test standby done");
	endtask

	task automatic t_tbclear();
		int i;
		for (i = 0; i < 600 && sub_presc !== 5'h04; i++) @(posedge clk_sys);
		if (i == 600) n_errors++;
		wr_reg(4'h2, 8'h0c);
		#1 chk(16'(sub_presc), 16'h0000);
		rd_chk(4'h2, 8'h00);
		$display("test time base clear done");
	endtask

	task automatic t_pinreset();
		ppm_cpu_model_inst.do_sleep();
		wait_mode(7'h04);
		ppm_cpu_model_inst.pin_reset(8);
		wait_mode(7'h01);
		chk(16'(power_status.cpu_reset), 16'h0001);
		wait_mode(7'h02);
		$display("test pin reset done");
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		n_errors = 0;
		checks_done = 0;
		reset = 1'b1;
		irq_enable = 8'hff;
		ccr_mask = 1'b0;
		bus_req = '0;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_div();
		t_sleep();
		t_subsleep();
		t_standby();
		t_tbclear();
		t_pinreset();
		print_verdict();
	end

	// overall hang guard
	initial begin
		#1000000;
		n_errors++;
		print_verdict();
	end
endmodule // tb_top
